// file: src/srlc_top.sv
// The register addresses and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps
// Contract
// - Disabled latch gates off both pin outputs
// - Select 111 pulses every 512 cycles
// - Select 101 pulses every 128 cycles
// - Select 011 pulses every 32 cycles
// - Select 010 pulses every 16 cycles
// - Select 000 pulses every 4 cycles
// - True output drives pin when enabled
// - Complement output drives pin when enabled
// - Reset pulse bit pulses reset once
module srlc_top (
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Register port
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    // External set and reset sources
    input wire logic periph_set_i,
    input wire logic periph_reset_i,
    // Pins
    output logic true_output_pin_o,
    output logic true_output_pin_oe_o,
    output logic complement_output_pin_o,
    output logic complement_output_pin_oe_o,
    // Status
    output logic latch_q_o,
    output logic divider_tick_o
);

    // ********************************
    // State
    // ********************************
    srlc_pkg::srlc_top_s st;
    srlc_pkg::srlc_top_s next_st;
    logic latch_global_enable;
    logic [2:0] pulse_divider_select;
    logic true_output_pin_enable;
    logic complement_output_pin_enable;
    logic peripheral_set_enable;
    logic tick;
    logic q;
    logic set_in;
    logic reset_in;

    assign latch_global_enable = st.main_ctl[srlc_pkg::BIT_EN];
    assign pulse_divider_select =
        st.main_ctl[srlc_pkg::BIT_SEL_HI:srlc_pkg::BIT_SEL_LO];
    assign true_output_pin_enable = st.main_ctl[srlc_pkg::BIT_QEN];
    assign complement_output_pin_enable = st.main_ctl[srlc_pkg::BIT_NQEN];
    assign peripheral_set_enable = st.src_ctl[srlc_pkg::BIT_PSE];

    // ********************************
    // Registers and pulses
    // ********************************
    always_comb begin
        next_st = st;
        next_st.set_p = 1'b0;
        next_st.rst_p = 1'b0;
        next_st.sync_set = {st.sync_set[0], periph_set_i};
        next_st.sync_rst = {st.sync_rst[0], periph_reset_i};
        if (wr_i && addr_i == srlc_pkg::ADDR_MAIN) begin
            // Pulse bits are not stored, they only fire
            next_st.main_ctl = wdata_i;
            next_st.main_ctl[srlc_pkg::BIT_SPULSE] = 1'b0;
            next_st.main_ctl[srlc_pkg::BIT_RPULSE] = 1'b0;
            next_st.set_p = wdata_i[srlc_pkg::BIT_SPULSE];
            next_st.rst_p = wdata_i[srlc_pkg::BIT_RPULSE];
        end
        if (wr_i && addr_i == srlc_pkg::ADDR_SRC) begin
            next_st.src_ctl = wdata_i;
        end
        next_st.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                srlc_pkg::ADDR_MAIN: next_st.rdata = st.main_ctl;
                srlc_pkg::ADDR_SRC: next_st.rdata = st.src_ctl;
                default: next_st.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st.main_ctl <= srlc_pkg::MAIN_RST;
            st.src_ctl <= srlc_pkg::SRC_RST;
            st.rdata <= 8'h00;
            st.set_p <= 1'b0;
            st.rst_p <= 1'b0;
            st.sync_set <= 2'h0;
            st.sync_rst <= 2'h0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    // ********************************
    // Divider and latch
    // ********************************
    srlc_divider i_srlc_divider (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .run_i(latch_global_enable),
        .sel_i(pulse_divider_select),
        .tick_o(tick)
    );

    assign set_in = st.set_p
        || (peripheral_set_enable && st.sync_set[1])
        || (st.src_ctl[srlc_pkg::BIT_DSE] && tick);
    assign reset_in = st.rst_p
        || (st.src_ctl[srlc_pkg::BIT_PRE] && st.sync_rst[1])
        || (st.src_ctl[srlc_pkg::BIT_DRE] && tick);

    srlc_core i_srlc_core (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .en_i(latch_global_enable),
        .set_i(set_in),
        .reset_i(reset_in),
        .q_o(q)
    );

    // ********************************
    // Pins
    // ********************************
    assign rdata_o = st.rdata;
    assign latch_q_o = q;
    assign divider_tick_o = tick;
    assign true_output_pin_o = q;
    assign complement_output_pin_o = ~q;
    assign true_output_pin_oe_o = latch_global_enable
        && true_output_pin_enable;
    assign complement_output_pin_oe_o = latch_global_enable
        && complement_output_pin_enable;

    // ********************************
    // Assertions
    // ********************************
    // Cycles since the last tick; armed at the first tick
    // under a steady select, so the first tick after a change is skipped
    int unsigned gap;
    logic armed;
    logic [2:0] sel_seen;
    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            gap <= 0;
            armed <= 1'b0;
            sel_seen <= 3'h0;
        end else if (ce_i) begin
            gap <= tick ? 0 : gap + 1;
            sel_seen <= pulse_divider_select;
            if (!latch_global_enable
                || pulse_divider_select != sel_seen) begin
                armed <= 1'b0;
            end else if (tick) begin
                armed <= 1'b1;
            end
        end
    end

    property p_disabled_off;
        @(posedge clk_sys_i) disable iff (rst_i)
        !latch_global_enable |->
            !true_output_pin_oe_o && !complement_output_pin_oe_o;
    endproperty
    a_disabled_off: assert property (p_disabled_off)
        else $error("pin enabled while latch disabled");

    property p_sel7;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && latch_global_enable && pulse_divider_select == 3'h7
            && $past(tick) && $stable(pulse_divider_select))
            |-> !tick [*8];
    endproperty
    a_sel7: assert property (p_sel7)
        else $error("512 period pulse too early");

    property p_sel5;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && tick && latch_global_enable
            && pulse_divider_select == 3'h5) |=> !tick [*8];
    endproperty
    a_sel5: assert property (p_sel5)
        else $error("128 period broken");

    property p_sel3;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && tick && latch_global_enable
            && pulse_divider_select == 3'h3) |=> !tick [*8];
    endproperty
    a_sel3: assert property (p_sel3)
        else $error("32 period pulse too early");

    property p_sel2;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && tick && latch_global_enable
            && pulse_divider_select == 3'h2) |=> !tick [*8];
    endproperty
    a_sel2: assert property (p_sel2)
        else $error("16 period pulse too early");

    property p_sel0;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && tick && latch_global_enable
            && pulse_divider_select == 3'h0) |=> !tick [*3];
    endproperty
    a_sel0: assert property (p_sel0)
        else $error("4 period pulse too early");

    property p_one_wide;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && tick) |=> !tick;
    endproperty
    a_one_wide: assert property (p_one_wide)
        else $error("divider pulse wider than one cycle");

    property p_qpin;
        @(posedge clk_sys_i) disable iff (rst_i)
        true_output_pin_oe_o |-> true_output_pin_o == q;
    endproperty
    a_qpin: assert property (p_qpin)
        else $error("true pin does not follow latch");

    property p_nqpin;
        @(posedge clk_sys_i) disable iff (rst_i)
        complement_output_pin_oe_o |-> complement_output_pin_o == !q;
    endproperty
    a_nqpin: assert property (p_nqpin)
        else $error("complement pin does not follow latch");

    property p_rpulse;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && wr_i && addr_i == srlc_pkg::ADDR_MAIN
            && wdata_i[srlc_pkg::BIT_RPULSE] && wdata_i[srlc_pkg::BIT_EN])
            ##1 ce_i |=> !q;
    endproperty
    a_rpulse: assert property (p_rpulse)
        else $error("reset pulse did not clear latch");

    property p_spulse;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && wr_i && addr_i == srlc_pkg::ADDR_MAIN
            && wdata_i[srlc_pkg::BIT_SPULSE]
            && !wdata_i[srlc_pkg::BIT_RPULSE]
            && wdata_i[srlc_pkg::BIT_EN] && st.src_ctl == 8'h00
            && !wr_i == 1'b0) ##1 (ce_i && !wr_i) |=> q;
    endproperty
    a_spulse: assert property (p_spulse)
        else $error("set pulse did not set latch");

    // Exact spacing: a steady select ticks once per period
    property p_per7;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tick && armed && sel_seen == 3'h7) |-> gap == 511;
    endproperty
    a_per7: assert property (p_per7)
        else $error("select 7 period is not 512");

    property p_per5;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tick && armed && sel_seen == 3'h5) |-> gap == 127;
    endproperty
    a_per5: assert property (p_per5)
        else $error("select 5 period is not 128");

    property p_per3;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tick && armed && sel_seen == 3'h3) |-> gap == 31;
    endproperty
    a_per3: assert property (p_per3)
        else $error("select 3 period is not 32");

    property p_per2;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tick && armed && sel_seen == 3'h2) |-> gap == 15;
    endproperty
    a_per2: assert property (p_per2)
        else $error("select 2 period is not 16");

    property p_per0;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tick && armed && sel_seen == 3'h0) |-> gap == 3;
    endproperty
    a_per0: assert property (p_per0)
        else $error("select 0 period is not 4");

    property p_per6;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tick && armed && sel_seen == 3'h6) |-> gap == 255;
    endproperty
    a_per6: assert property (p_per6)
        else $error("select 6 period is not 256");

    property p_per4;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tick && armed && sel_seen == 3'h4) |-> gap == 63;
    endproperty
    a_per4: assert property (p_per4)
        else $error("select 4 period is not 64");

    property p_per1;
        @(posedge clk_sys_i) disable iff (rst_i)
        (tick && armed && sel_seen == 3'h1) |-> gap == 7;
    endproperty
    a_per1: assert property (p_per1)
        else $error("select 1 period is not 8");

    property p_qen_wr;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && wr_i && addr_i == srlc_pkg::ADDR_MAIN) |=>
            true_output_pin_oe_o == ($past(wdata_i[srlc_pkg::BIT_EN])
            && $past(wdata_i[srlc_pkg::BIT_QEN]));
    endproperty
    a_qen_wr: assert property (p_qen_wr)
        else $error("true pin enable does not follow write");

    property p_nqen_wr;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && wr_i && addr_i == srlc_pkg::ADDR_MAIN) |=>
            complement_output_pin_oe_o == ($past(wdata_i[srlc_pkg::BIT_EN])
            && $past(wdata_i[srlc_pkg::BIT_NQEN]));
    endproperty
    a_nqen_wr: assert property (p_nqen_wr)
        else $error("complement pin enable does not follow write");

    property p_core_off;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && !latch_global_enable) |=> !q;
    endproperty
    a_core_off: assert property (p_core_off)
        else $error("latch held state while disabled");

    property p_pulse_rd0;
        @(posedge clk_sys_i) disable iff (rst_i)
        (ce_i && rd_i && addr_i == srlc_pkg::ADDR_MAIN) |=>
            !rdata_o[srlc_pkg::BIT_SPULSE] && !rdata_o[srlc_pkg::BIT_RPULSE];
    endproperty
    a_pulse_rd0: assert property (p_pulse_rd0)
        else $error("pulse bits read back as one");

    c_per7: cover property (@(posedge clk_sys_i)
        tick && armed && sel_seen == 3'h7);
    c_tick: cover property (@(posedge clk_sys_i) tick);
    c_qpin: cover property (@(posedge clk_sys_i) true_output_pin_oe_o && q);
    c_nq: cover property (@(posedge clk_sys_i) complement_output_pin_oe_o);

endmodule

// file: src/srlc_pkg.sv
package srlc_pkg;

    // ********************************
    // Register map
    // ********************************
    localparam logic [3:0] ADDR_MAIN = 4'h0;
    localparam logic [3:0] ADDR_SRC = 4'h1;
    localparam int REG_W = 8;

    // Main control register fields
    localparam int BIT_EN = 7;
    localparam int BIT_SEL_HI = 6;
    localparam int BIT_SEL_LO = 4;
    localparam int BIT_QEN = 3;
    localparam int BIT_NQEN = 2;
    localparam int BIT_SPULSE = 1;
    localparam int BIT_RPULSE = 0;

    // Source enable register fields
    localparam int BIT_PSE = 7;
    localparam int BIT_DSE = 6;
    localparam int BIT_PRE = 3;
    localparam int BIT_DRE = 2;

    localparam logic [7:0] MAIN_RST = 8'h00;
    localparam logic [7:0] SRC_RST = 8'h00;

    // ********************************
    // Divider
    // ********************************
    localparam int DIV_W = 9;
    localparam int MIN_SHIFT = 2;
    localparam logic [8:0] DIV_ZERO = 9'h000;

    // ********************************
    // State carriers
    // ********************************
    typedef struct packed {
        logic [8:0] cnt;
        logic tick;
    } srlc_div_s;

    typedef struct packed {
        logic q;
    } srlc_core_s;

    typedef struct packed {
        logic [7:0] main_ctl;
        logic [7:0] src_ctl;
        logic [7:0] rdata;
        logic set_p;
        logic rst_p;
        logic [1:0] sync_set;
        logic [1:0] sync_rst;
    } srlc_top_s;

endpackage

// file: src/srlc_divider.sv
`timescale 1ns/1ps
module srlc_divider (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Control
    input wire logic run_i,
    input wire logic [2:0] sel_i,
    // Pulse out
    output logic tick_o
);

    srlc_pkg::srlc_div_s st;
    srlc_pkg::srlc_div_s next_st;
    logic [8:0] last;

    // period select
    // Period is 2**(sel+2); last count is period minus one.
    // Shift amount is widened so selects 6 and 7 do not wrap
    function automatic logic [8:0] period_last(input logic [2:0] s);
        logic [9:0] p;
        p = 10'h001 << (4'(s) + 4'(srlc_pkg::MIN_SHIFT));
        return 9'(p - 10'h001);
    endfunction

    always_comb begin
        last = period_last(sel_i);
        next_st = st;
        next_st.tick = 1'b0;
        if (!run_i) begin
            next_st.cnt = srlc_pkg::DIV_ZERO;
        end else if (st.cnt >= last) begin
            next_st.cnt = srlc_pkg::DIV_ZERO;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 9'h001;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign tick_o = st.tick;

endmodule

// file: src/srlc_core.sv
`timescale 1ns/1ps
module srlc_core (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Latch inputs
    input wire logic en_i,
    input wire logic set_i,
    input wire logic reset_i,
    // Latch output
    output logic q_o
);

    srlc_pkg::srlc_core_s st;
    srlc_pkg::srlc_core_s next_st;

    // Reset dominates when both inputs are active in one cycle
    always_comb begin
        next_st = st;
        if (!en_i) begin
            next_st.q = 1'b0;
        end else if (reset_i) begin
            next_st.q = 1'b0;
        end else if (set_i) begin
            next_st.q = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else if (ce_i) begin
            st <= next_st;
        end
    end

    assign q_o = st.q;

endmodule

// file: dv/srlc_far_model.sv
`timescale 1ns/1ps
// ********************************
// Far side: pin pads and peripheral sources
// ********************************
module srlc_far_model (
    // Clock
    input wire logic clk_sys_i,
    // Pins from the block
    input wire logic q_i,
    input wire logic q_oe_i,
    input wire logic nq_i,
    input wire logic nq_oe_i,
    // Bench commands
    input wire logic set_req_i,
    input wire logic reset_req_i,
    // Pads and sources
    output logic q_pad_o,
    output logic nq_pad_o,
    output logic periph_set_o,
    output logic periph_reset_o
);
    logic q_last = 1'b0;
    logic nq_last = 1'b0;
    logic [1:0] s_cnt = 2'h0;
    logic [1:0] r_cnt = 2'h0;

    always_ff @(posedge clk_sys_i) begin
        if (q_oe_i) q_last <= q_i;
        if (nq_oe_i) nq_last <= nq_i;
        s_cnt <= set_req_i ? 2'h3 : (s_cnt != 2'h0 ? s_cnt - 2'h1 : 2'h0);
        r_cnt <= reset_req_i ? 2'h3 : (r_cnt != 2'h0 ? r_cnt - 2'h1 : 2'h0);
    end

    // Undriven pad floats: show inverse so a stale value never matches
    assign q_pad_o = q_oe_i ? q_i : ~q_last;
    assign nq_pad_o = nq_oe_i ? nq_i : ~nq_last;
    // Held three cycles so the two-flop sync cannot miss them
    assign periph_set_o = s_cnt != 2'h0;
    assign periph_reset_o = r_cnt != 2'h0;
endmodule

// file: dv/srlc_top_tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checked++; if ((got) !== (ex)) begin \
    error_cnt++; $display("[FAIL] %s exp %0h got %0h", nm, ex, got); end end
module srlc_top_tb;
    logic clk_sys_i, rst_i, ce_i, wr_i, rd_i, set_req, rst_req;
    logic [3:0] addr_i;
    logic [7:0] wdata_i, rdata_o;
    logic q_pin, q_oe, nq_pin, nq_oe, latch_q, tick, q_pad, nq_pad;
    logic p_set, p_rst;
    logic [3:0] pins;
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    int n;

    assign pins = {q_pin, q_oe, nq_pin, nq_oe};

    srlc_top i_srlc_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .ce_i(ce_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
        .rdata_o(rdata_o), .periph_set_i(p_set), .periph_reset_i(p_rst),
        .true_output_pin_o(q_pin), .true_output_pin_oe_o(q_oe),
        .complement_output_pin_o(nq_pin),
        .complement_output_pin_oe_o(nq_oe), .latch_q_o(latch_q),
        .divider_tick_o(tick));

    srlc_far_model i_srlc_far_model (.clk_sys_i(clk_sys_i), .q_i(q_pin),
        .q_oe_i(q_oe), .nq_i(nq_pin), .nq_oe_i(nq_oe), .set_req_i(set_req),
        .reset_req_i(rst_req), .q_pad_o(q_pad), .nq_pad_o(nq_pad),
        .periph_set_o(p_set), .periph_reset_o(p_rst));

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // ********************************
    // Tasks
    // ********************************
    task automatic tally_and_finish;
        $display("checked %0d error_cnt %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] ex);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        `CHK("rdata", ex, rdata_o)
    endtask

    task automatic settle;
        repeat (4) @(posedge clk_sys_i);
        #1;
    endtask

    // Tick to tick distance; also checks the pulse is one cycle wide
    task automatic meas(output int p);
        int k;
        k = 0;
        while (tick !== 1'b1 && k < 1000) begin
            @(posedge clk_sys_i);
            #1;
            k++;
        end
        @(posedge clk_sys_i);
        #1;
        `CHK("tick_width", 1'b0, tick)
        p = 1;
        while (tick !== 1'b1 && p < 1000) begin
            @(posedge clk_sys_i);
            #1;
            p++;
        end
    endtask

    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            tally_and_finish;
        end
    end

    // ********************************
    // Sequence
    // ********************************
    initial begin
        rst_i = 1'b1;
        ce_i = 1'b1;
        addr_i = 4'h0;
        wdata_i = 8'h00;
        wr_i = 1'b0;
        rd_i = 1'b0;
        set_req = 1'b0;
        rst_req = 1'b0;
        repeat (6) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(srlc_pkg::ADDR_MAIN, srlc_pkg::MAIN_RST);
        rd(srlc_pkg::ADDR_SRC, srlc_pkg::SRC_RST);
        wr(srlc_pkg::ADDR_SRC, 8'h33);
        rd(srlc_pkg::ADDR_SRC, 8'h33);
        rd(4'hF, 8'h00);
        wr(srlc_pkg::ADDR_SRC, 8'h00);
        wr(srlc_pkg::ADDR_MAIN, 8'h0E);
        settle;
        `CHK("pins_disabled", 4'h0, pins[2:0] & 3'h5)
        `CHK("q_disabled", 1'b0, latch_q)
        wr(srlc_pkg::ADDR_MAIN, 8'h8E);
        settle;
        `CHK("q_after_set", 1'b1, latch_q)
        `CHK("pins_both", 4'hD, pins)
        `CHK("q_pad", 1'b1, q_pad)
        rd(srlc_pkg::ADDR_MAIN, 8'h8C);
        wr(srlc_pkg::ADDR_MAIN, 8'h88);
        settle;
        `CHK("pins_q_only", 4'hC, pins)
        wr(srlc_pkg::ADDR_MAIN, 8'h84);
        settle;
        `CHK("q_zero_bits", 1'b1, latch_q)
        wr(srlc_pkg::ADDR_MAIN, 8'h85);
        settle;
        `CHK("pins_nq_only", 4'h3, pins)
        `CHK("nq_pad", 1'b1, nq_pad)
        wr(srlc_pkg::ADDR_MAIN, 8'h84);
        settle;
        `CHK("q_no_set", 1'b0, latch_q)
        wr(srlc_pkg::ADDR_SRC, 8'h80);
        set_req <= 1'b1;
        @(posedge clk_sys_i);
        set_req <= 1'b0;
        settle;
        `CHK("q_periph_set", 1'b1, latch_q)
        wr(srlc_pkg::ADDR_SRC, 8'h08);
        rst_req <= 1'b1;
        @(posedge clk_sys_i);
        rst_req <= 1'b0;
        settle;
        `CHK("q_periph_rst", 1'b0, latch_q)
        // Divider tick as set source, then as reset source
        wr(srlc_pkg::ADDR_SRC, 8'h40);
        settle;
        settle;
        `CHK("q_div_set", 1'b1, latch_q)
        wr(srlc_pkg::ADDR_SRC, 8'h04);
        settle;
        settle;
        `CHK("q_div_rst", 1'b0, latch_q)
        wr(srlc_pkg::ADDR_SRC, 8'h00);
        ce_i <= 1'b0;
        wr(srlc_pkg::ADDR_MAIN, 8'h00);
        ce_i <= 1'b1;
        rd(srlc_pkg::ADDR_MAIN, 8'h84);
        // Every select code, period 2**(sel+2)
        for (int s = 0; s < 8; s++) begin
            wr(srlc_pkg::ADDR_MAIN, 8'h00);
            wr(srlc_pkg::ADDR_MAIN, {1'b1, s[2:0], 4'h0});
            meas(n);
            `CHK("period", 2 ** (s + 2), n)
        end
        // Reset in mid-run returns everything to idle
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        settle;
        `CHK("pins_reset", 4'h2, pins)
        `CHK("q_reset", 1'b0, latch_q)
        @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rd(srlc_pkg::ADDR_MAIN, srlc_pkg::MAIN_RST);
        tally_and_finish;
    end
endmodule
